// File: pkg/misc_ctrl_pkg.sv
// Purpose: constants for the switch misc control register bank
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: printed offsets are register indexes; byte address is index * 4
package misc_ctrl_pkg;
   localparam int NUM_PORTS = 5;
   localparam int ADDR_W = 12;
   // register indexes as printed
   localparam logic [7:0] IDX_Q3_P1 = 8'hBE;
   localparam logic [7:0] IDX_Q3_P2 = 8'hCE;
   localparam logic [7:0] IDX_Q3_P3 = 8'hDE;
   localparam logic [7:0] IDX_Q3_P4 = 8'hEE;
   localparam logic [7:0] IDX_Q3_P5 = 8'hFE;
   localparam logic [7:0] IDX_TEST_ONE = 8'hBF;
   localparam logic [7:0] IDX_TEST_TWO = 8'hDF;
   localparam logic [7:0] IDX_P3_MEDIUM = 8'hEF;
   localparam logic [7:0] IDX_TEST_THREE = 8'hFF;
   // fields
   localparam int RATE_W = 7;
   localparam int FIBER_BIT = 7;
   localparam int CLK_INV_BIT = 4;
   // reset values
   localparam logic [6:0] RATE_RST = 7'h00;
   localparam logic [7:0] TEST_ONE_RST = 8'h80;
   localparam logic [7:0] TEST_TWO_RST = 8'h0C;
   localparam logic [6:0] P3_MEDIUM_LOW_RST = 7'h32;
   localparam logic [7:0] TEST_THREE_RST = 8'h00;
   // rate decode
   localparam logic [6:0] RATE_MBPS_MAX = 7'h63;
   localparam logic [6:0] RATE_UNLIMITED = 7'h64;
   localparam logic [6:0] RATE_KBPS_MIN = 7'h65;
   localparam logic [6:0] RATE_KBPS_MAX = 7'h73;
   localparam logic [16:0] KBPS_STEP = 17'h00040;
   localparam logic [16:0] KBPS_PER_MBPS = 17'h003E8;
endpackage : misc_ctrl_pkg

// File: verif/misc_ctrl_chk.sv
// Purpose: port-level checks of the misc control bank
// Assumes: zero wait apb, synced inputs settle within 3 cycles
// Notes: bound onto the design from tb
`timescale 1ns/1ps
`default_nettype none
module misc_ctrl_chk
   import misc_ctrl_pkg::*;
#(parameter int PORTS = 5) (
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic rmii_mode, rx_clock_ref, port3_fiber,
   input wire logic switch_rmii_rx_clock_out,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb,
   input wire logic [PORTS-1:0] four_queue_mode, q3_top_priority,
   input wire logic [PORTS-1:0] q3_exact_rate,
   input wire logic [PORTS*17-1:0] q3_rate_kbps
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic inv_reg;
   wire logic wr = psel && penable && pwrite && pstrb[0];
   wire logic ok = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0
      && paddr[9:6] > 4'hA && (paddr[5:2] == 4'hE
      || (paddr[5:2] == 4'hF && paddr[9:6] != 4'hC));
   function automatic logic [16:0] kb(logic [6:0] v);
      if (v != 7'h0 && v <= RATE_MBPS_MAX) return 17'(v) * KBPS_PER_MBPS;
      if (v >= RATE_KBPS_MIN && v <= RATE_KBPS_MAX)
         return 17'(v - RATE_UNLIMITED) * KBPS_STEP;
      return 17'h0;
   endfunction : kb
   // shadow of the invert bit, the checker cannot see the register
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) inv_reg <= 1'h0;
      else if (wr && paddr == 12'h3FC) inv_reg <= pwdata[CLK_INV_BIT];
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   a_err_map: assert property (pready |-> pslverr == !ok)
      else $error("pslverr wrong for address");
   a_test_fixed: assert property (pready && !pwrite && paddr == 12'h2FC
      |-> prdata == 32'h80) else $error("test register value wrong");
   a_rate_out: assert property (wr && paddr == 12'h2F8
      |-> ##2 q3_rate_kbps[16:0] == kb($past(pwdata[6:0], 2)))
      else $error("port 1 rate decode wrong");
   a_fiber_sel: assert property (wr && paddr == 12'h3BC
      |-> ##2 port3_fiber == $past(pwdata[FIBER_BIT], 2))
      else $error("fiber select wrong");
   a_clk_inv: assert property (($stable(rx_clock_ref) && $stable(rmii_mode)
      && !wr) [*5] |-> switch_rmii_rx_clock_out
      == (rx_clock_ref ^ (rmii_mode & inv_reg))) else $error("rx clock wrong");
   a_top_prio: assert property ($stable(four_queue_mode) [*5]
      |-> q3_top_priority == four_queue_mode) else $error("top priority wrong");
   a_exact_rate: assert property (1'h1 |=> &q3_exact_rate)
      else $error("exact rate flag low");
endmodule : misc_ctrl_chk
`default_nettype wire

// File: verif/tb.sv
// Purpose: self-checking bench for the misc control bank
// Assumes: apb answers one cycle after setup
// Notes: results compared at the rising edge that samples pready high
`timescale 1ns/1ps
`default_nettype none
module tb;
   import misc_ctrl_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic rmii_mode = 0, rx_clock_ref = 0, pready, pslverr;
   logic port3_fiber, switch_rmii_rx_clock_out;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hF;
   logic [4:0] four_queue_mode = 5'h0, q3_top_priority, q3_exact_rate;
   logic [84:0] q3_rate_kbps;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   logic [15:0] rnd = 16'h3859;
   logic [7:0] v;
   logic [11:0] ra[5] = '{12'h2F8, 12'h338, 12'h378, 12'h3B8, 12'h3F8};
   logic [6:0] bv[5] = '{7'h01, 7'h63, 7'h64, 7'h65, 7'h73};
   logic [11:0] ta[4] = '{12'h2FC, 12'h37C, 12'h3BC, 12'h3FC};
   logic [31:0] tr[4] = '{32'h80, 32'h0C, 32'h32, 32'h00};
   logic [31:0] tw[4] = '{32'h80, 32'h0C, 32'hB2, 32'h10};
   int bad_count = 0, compares = 0, cyc = 0;
   switch_port_misc_control dut (.*);
   initial forever #5 pclk = ~pclk;
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [31:0] kbps(logic [6:0] n);
      if (n != 7'h0 && n <= RATE_MBPS_MAX) return 32'(n) * 32'h3E8;
      if (n >= RATE_KBPS_MIN && n <= RATE_KBPS_MAX)
         return 32'(n - RATE_UNLIMITED) * 32'h40;
      return 32'h0;
   endfunction : kbps
   task automatic chk(string n, logic [31:0] x, logic [31:0] y);
      compares++;
      if (x !== y) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, x, y);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic xfer(logic [11:0] a, logic w, logic [31:0] d,
      logic [3:0] s, logic [31:0] x, logic er);
      @(posedge pclk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      exp_q.push_back({~w, er, x});
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : xfer
   always @(posedge pclk) if (pready === 1'h1) begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) chk("prdata", e[31:0], prdata);
   end
   // slow random pins leave stable windows for the synchronisers
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc % 8 == 0) begin
         rnd <= lfsr(rnd);
         rx_clock_ref <= rnd[0];
         four_queue_mode <= rnd[5:1];
      end
      if (cyc == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      foreach (ra[i]) xfer(ra[i], 0, 0, 4'hF, 0, 0);
      for (int k = 0; k < 4; k++) begin
         xfer(ta[k], 0, 0, 4'hF, tr[k], 0);
         xfer(ta[k], 1, 32'hFFFFFFFF, 4'hF, 0, 0);
         xfer(ta[k], 0, 0, 4'hF, tw[k], 0);
      end
      xfer(12'h3BC, 1, 0, 4'h0, 0, 0);
      xfer(12'h3BC, 0, 0, 4'hF, 32'hB2, 0);
      rmii_mode <= 1'h1;
      for (int k = 0; k < 2; k++) foreach (ra[i]) begin
         v = k ? rnd[7:0] : {1'h1, bv[i]};
         xfer(ra[i], 1, {24'h0, v}, 4'hF, 0, 0);
         repeat (2) @(posedge pclk);
         chk("rate", kbps(v[6:0]), 32'(q3_rate_kbps[i*17 +: 17]));
         xfer(ra[i], 0, 0, 4'hF, {24'h0, v & 8'h7F}, 0);
      end
      xfer(12'h004, 0, 0, 4'hF, 0, 1);
      xfer(12'h2F9, 0, 0, 4'hF, 0, 1);
      xfer(12'h33C, 1, 32'h5, 4'hF, 0, 1);
      repeat (40) @(posedge pclk);
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      xfer(12'h3BC, 0, 0, 4'hF, 32'h32, 0);
      tally_and_finish();
   end
endmodule : tb
bind switch_port_misc_control misc_ctrl_chk #(.PORTS(PORTS)) chk (.*);
`default_nettype wire

// File: verilog/switch_port_misc_control.sv
// Purpose: queue 3 egress limits, port 3 medium select, rx clock invert
// Assumes: apb slave, zero wait states, pslverr on unmapped address
// Notes: rate outputs are in kbps, zero means unlimited
// Function
// R01: each port has a 7-bit r/w queue 3 egress limit, reset zero.
// R02: in four queue mode queue 3 is the highest scheduling priority.
// R03: a r/w bit selects port 3 copper when 0 (reset) or fiber when 1.
// R04: the clock-invert bit inverts the port 5 rmii rx clock output phase. The code inverts only while the synced rmii_mode is high.
// R05: software sets related ports to two or four queue mode first.
// R06: only the top queue gets the exact rate; others follow weights. The code sets q3_exact_rate in every mode.
// R07: values 1-99 are mbps, 0 or 100 unlimited, 101-115 are 64 kbps steps.
// R08: test registers read fixed values and ignore writes. Test register three keeps bit 4 writable as the clock-invert bit.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module switch_port_misc_control
   import misc_ctrl_pkg::*;
#(
   parameter int PORTS = misc_ctrl_pkg::NUM_PORTS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [misc_ctrl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [PORTS-1:0] four_queue_mode,
   input wire logic rmii_mode,
   input wire logic rx_clock_ref,
   output logic port3_fiber,
   output logic switch_rmii_rx_clock_out,
   output logic [PORTS-1:0] q3_top_priority,
   output logic [PORTS-1:0] q3_exact_rate,
   output logic [PORTS*17-1:0] q3_rate_kbps
);
   import misc_ctrl_pkg::*;

   logic [6:0] q3_limit_reg [PORTS];
   logic fiber_reg;
   logic clk_inv_reg;
   logic [1:0] rx_ref_sync_reg;
   logic [1:0] rmii_sync_reg;
   logic [PORTS-1:0] fourq_sync0_reg;
   logic [PORTS-1:0] fourq_sync1_reg;
   logic [7:0] idx;
   logic in_range;
   logic wr_lane0;
   logic access;
   logic setup;
   logic [31:0] rd_data_next;
   logic rd_err_next;

   // decode kbps from the shared rate field, zero is unlimited
   function automatic logic [16:0] rate_to_kbps(input logic [6:0] v);
      logic [16:0] r;
      r = 17'h00000;
      if (v >= 7'h01 && v <= RATE_MBPS_MAX) begin
         r = 17'({10'h000, v} * KBPS_PER_MBPS); // R07
      end else if (v >= RATE_KBPS_MIN && v <= RATE_KBPS_MAX) begin
         r = 17'({10'h000, 7'(v - RATE_UNLIMITED)} * KBPS_STEP); // R07
      end
      return r;
   endfunction : rate_to_kbps

   // port number 0..PORTS-1 for a queue 3 index, PORTS if none
   function automatic int q3_port(input logic [7:0] a);
      case (a)
         IDX_Q3_P1: return 0;
         IDX_Q3_P2: return 1;
         IDX_Q3_P3: return 2;
         IDX_Q3_P4: return 3;
         IDX_Q3_P5: return 4;
         default: return PORTS;
      endcase
   endfunction : q3_port

   assign idx = paddr[9:2];
   assign in_range = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
   assign access = psel && penable;
   assign setup = psel && !penable;
   assign wr_lane0 = access && pwrite && pstrb[0] && in_range;

   generate
      for (genvar p = 0; p < PORTS; p++) begin : g_port
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               q3_limit_reg[p] <= RATE_RST; // R01
            end else if (wr_lane0 && q3_port(idx) == p) begin
               q3_limit_reg[p] <= pwdata[RATE_W-1:0]; // R01
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               q3_rate_kbps[p*17 +: 17] <= 17'h00000;
               q3_top_priority[p] <= 1'b0;
               q3_exact_rate[p] <= 1'b0;
            end else begin
               q3_rate_kbps[p*17 +: 17] <= rate_to_kbps(q3_limit_reg[p]); // R07
               // queue 3 leads in four queue mode; exact rate set in every mode
               q3_top_priority[p] <= fourq_sync1_reg[p]; // R02
               q3_exact_rate[p] <= 1'b1; // R06
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fourq_sync0_reg <= '0;
         fourq_sync1_reg <= '0;
         rx_ref_sync_reg <= 2'b00;
         rmii_sync_reg <= 2'b00;
      end else begin
         fourq_sync0_reg <= four_queue_mode;
         fourq_sync1_reg <= fourq_sync0_reg;
         rx_ref_sync_reg <= {rx_ref_sync_reg[0], rx_clock_ref};
         rmii_sync_reg <= {rmii_sync_reg[0], rmii_mode};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fiber_reg <= 1'b0; // R03
      end else if (wr_lane0 && idx == IDX_P3_MEDIUM) begin
         fiber_reg <= pwdata[FIBER_BIT]; // R03
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_inv_reg <= 1'b0; // R04
      end else if (wr_lane0 && idx == IDX_TEST_THREE) begin
         clk_inv_reg <= pwdata[CLK_INV_BIT]; // R04
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port3_fiber <= 1'b0;
         switch_rmii_rx_clock_out <= 1'b0;
      end else begin
         port3_fiber <= fiber_reg; // R03
         // invert only in rmii mode; sampled clock, so phase is coarse
         switch_rmii_rx_clock_out <= rx_ref_sync_reg[1] ^
            (clk_inv_reg && rmii_sync_reg[1]); // R04
      end
   end

   // every index that decodes to a register of this bank
   function automatic logic idx_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         IDX_TEST_ONE: hit = 1'b1;
         IDX_TEST_TWO: hit = 1'b1;
         IDX_P3_MEDIUM: hit = 1'b1;
         IDX_TEST_THREE: hit = 1'b1;
         default: hit = (q3_port(a) < PORTS);
      endcase
      return hit;
   endfunction : idx_mapped

   // test registers one and two hold constants so writes never land (R08)
   always_comb begin
      rd_data_next = 32'h00000000;
      rd_err_next = !in_range || !idx_mapped(idx);
      if (!rd_err_next) begin
         if (q3_port(idx) < PORTS) begin
            rd_data_next = {25'h0000000, q3_limit_reg[q3_port(idx)]}; // R01
         end else begin
            case (idx)
               IDX_TEST_ONE: begin
                  rd_data_next = {24'h000000, TEST_ONE_RST}; // R08
               end
               IDX_TEST_TWO: begin
                  rd_data_next = {24'h000000, TEST_TWO_RST}; // R08
               end
               IDX_P3_MEDIUM: begin
                  rd_data_next = {24'h000000, fiber_reg,
                     P3_MEDIUM_LOW_RST}; // R03
               end
               IDX_TEST_THREE: begin
                  rd_data_next = {27'h0000000, clk_inv_reg,
                     4'h0}; // R04
               end
               default: begin
                  rd_data_next = 32'h00000000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         // zero wait states: answer in the access cycle after setup
         pready <= setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && rd_err_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= rd_data_next;
      end else begin
         prdata <= 32'h00000000;
      end
   end
endmodule : switch_port_misc_control
`default_nettype wire
